// ===== hdl/prx_map.svh
`ifndef PRX_MAP_SVH
`define PRX_MAP_SVH

// ----------------------------------------
// window and delimiter
// ----------------------------------------
`define PRX_WIN_W 10
`define PRX_SSD 10'h311
`define PRX_IDLE_WIN 10'h3FF
`define PRX_SSD_TAIL 3'h5
`define PRX_TAIL_LAST 3'h4

// ----------------------------------------
// far-end fault
// ----------------------------------------
`define PRX_FEF_ONES 7'h54
`define PRX_ONES_MAX 7'h7F
`define PRX_FEF_CYCLES 2'h3

// ----------------------------------------
// link qualification time
// ----------------------------------------
`define PRX_QUAL_US 500
`define PRX_CLK_NS 10
`define PRX_QUAL_CYCLES ((`PRX_QUAL_US * 1000 + `PRX_CLK_NS - 1) / `PRX_CLK_NS)

// ----------------------------------------
// transmit buffer
// ----------------------------------------
`define PRX_FIFO_DEPTH 16
`define PRX_FIFO_W 1

`endif

// ===== hdl/prx_pkg.sv
`default_nettype none

package prx_pkg;

  typedef enum logic [1:0] {
    PRX_LC_DISABLE,
    PRX_LC_SCAN,
    PRX_LC_ENABLE
  } prx_link_ctrl_type;

  typedef enum logic [1:0] {
    PRX_LINK_FAIL,
    PRX_LINK_READY,
    PRX_LINK_OK
  } prx_link_type;

  typedef enum logic [1:0] {
    PRX_CARR_IDLE,
    PRX_CARR_CHECK,
    PRX_CARR_ACTIVE
  } prx_carrier_type;

endpackage

`default_nettype wire

// ===== hdl/prx_fifo.sv
`default_nettype none

module prx_fifo #(
  parameter int W = 1,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      wr_ptr <= wr_ptr + 1'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'h1;
    end
  end

endmodule

`default_nettype wire

// ===== hdl/prx_top.sv
`include "prx_map.svh"

`default_nettype none

module prx_top
  import prx_pkg::*;
#(
  parameter logic [15:0] QUAL_CYCLES = 16'(`PRX_QUAL_CYCLES)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // options
  input wire logic carrier_enable,
  input wire logic fef_enable,
  input wire logic an_present,
  input wire prx_link_ctrl_type link_control,
  // transceiver receive side
  input wire logic rx_nrzi,
  input wire logic signal_change_report,
  // transceiver transmit side
  output logic tx_nrzi,
  output logic line_tx_transfer,
  // client transmit code-bits
  input wire logic tx_code_valid,
  output logic tx_code_ready,
  input wire logic tx_code_bit,
  // client receive code-bits
  output logic line_rx_transfer,
  output logic rx_code_bit,
  // status
  output logic carrier_on,
  output logic rx_error,
  output prx_link_type link_status,
  output logic far_end_fault
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic split_zeros(input logic [`PRX_WIN_W-1:0] w);
    logic found;
    found = 1'h0;
    for (int i = 0; i < `PRX_WIN_W; i++) begin
      for (int j = i + 2; j < `PRX_WIN_W; j++) begin
        if (!w[i] && !w[j]) begin
          found = 1'h1;
        end
      end
    end
    return found;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic rx_level, rx_prev, cbit, qualified, gen_fault, gen_bit, code_out;
  logic fifo_valid, fifo_data, fifo_take;
  logic [`PRX_WIN_W-1:0] win, next_win;
  logic [2:0] tail;
  logic [1:0] cycles;
  logic [6:0] ones, gen_cnt;
  logic [15:0] timer;
  prx_carrier_type cstate;
  prx_link_ctrl_type lc_eff;
  prx_link_type link_state;

  // ----------------------------------------
  // receive decode
  // ----------------------------------------
  // an undefined bit while the signal is bad must not fake activity
  assign rx_level = signal_change_report & rx_nrzi;
  assign cbit = rx_level ^ rx_prev;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_prev <= 1'b0;
    end else begin
      rx_prev <= rx_level;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_code_bit <= 1'b0;
      line_rx_transfer <= 1'b0;
    end else begin
      rx_code_bit <= cbit;
      line_rx_transfer <= 1'b1;
    end
  end

  // ----------------------------------------
  // carrier detect
  // ----------------------------------------
  assign next_win = {win[`PRX_WIN_W-2:0], cbit};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      win <= `PRX_IDLE_WIN;
    end else begin
      win <= next_win;
    end
  end

  // the delimiter's first zeros trigger detection; its last five bits
  // arrive afterwards, so the full pattern is compared five bits later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cstate <= PRX_CARR_IDLE;
      tail <= 3'h0;
      rx_error <= 1'b0;
    end else if (!carrier_enable) begin
      cstate <= PRX_CARR_IDLE;
      tail <= 3'h0;
      rx_error <= 1'b0;
    end else begin
      case (cstate)
        PRX_CARR_IDLE: begin
          if (split_zeros(next_win)) begin
            cstate <= PRX_CARR_CHECK;
            tail <= 3'h0;
            rx_error <= 1'b0;
          end
        end
        PRX_CARR_CHECK: begin
          tail <= tail + 3'h1;
          if (next_win == `PRX_IDLE_WIN) begin
            cstate <= PRX_CARR_IDLE;
            rx_error <= 1'b0;
          end else if (tail == `PRX_TAIL_LAST) begin
            cstate <= PRX_CARR_ACTIVE;
            rx_error <= (next_win != `PRX_SSD);
          end
        end
        PRX_CARR_ACTIVE: begin
          if (next_win == `PRX_IDLE_WIN) begin
            cstate <= PRX_CARR_IDLE;
            rx_error <= 1'b0;
          end
        end
        default: begin
          cstate <= PRX_CARR_IDLE;
        end
      endcase
    end
  end

  assign carrier_on = (cstate != PRX_CARR_IDLE);

  // ----------------------------------------
  // link monitor
  // ----------------------------------------
  assign lc_eff = an_present ? link_control : PRX_LC_ENABLE;
  assign qualified = (timer == QUAL_CYCLES);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer <= 16'h0000;
    end else if (!signal_change_report) begin
      timer <= 16'h0000;
    end else if (!qualified) begin
      timer <= timer + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_state <= PRX_LINK_FAIL;
    end else if (!signal_change_report || lc_eff == PRX_LC_DISABLE) begin
      link_state <= PRX_LINK_FAIL;
    end else begin
      case (link_state)
        PRX_LINK_FAIL: begin
          if (qualified) begin
            link_state <= PRX_LINK_READY;
          end
        end
        PRX_LINK_READY: begin
          if (lc_eff == PRX_LC_ENABLE) begin
            link_state <= PRX_LINK_OK;
          end
        end
        PRX_LINK_OK: begin
          link_state <= PRX_LINK_OK;
        end
        default: begin
          link_state <= PRX_LINK_FAIL;
        end
      endcase
    end
  end

  assign link_status = link_state;

  // ----------------------------------------
  // far-end fault detect
  // ----------------------------------------
  // the run counter saturates so an endless idle never wraps into a match
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ones <= 7'h00;
    end else if (cbit) begin
      if (ones != `PRX_ONES_MAX) begin
        ones <= ones + 7'h01;
      end
    end else begin
      ones <= 7'h00;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cycles <= 2'h0;
    end else if (!fef_enable) begin
      cycles <= 2'h0;
    end else if (cbit) begin
      if (ones == `PRX_FEF_ONES && cycles != 2'h0) begin
        cycles <= 2'h0;
      end
    end else if (ones == `PRX_FEF_ONES || (cycles == 2'h0 && ones > `PRX_FEF_ONES)) begin
      if (cycles != `PRX_FEF_CYCLES) begin
        cycles <= cycles + 2'h1;
      end
    end else begin
      cycles <= 2'h0;
    end
  end

  assign far_end_fault = (cycles == `PRX_FEF_CYCLES);

  // ----------------------------------------
  // far-end fault generate
  // ----------------------------------------
  assign gen_fault = fef_enable && !signal_change_report;
  assign gen_bit = (gen_cnt != `PRX_FEF_ONES);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gen_cnt <= 7'h00;
    end else if (!gen_fault || gen_cnt == `PRX_FEF_ONES) begin
      gen_cnt <= 7'h00;
    end else begin
      gen_cnt <= gen_cnt + 7'h01;
    end
  end

  // ----------------------------------------
  // transmit buffer and nrzi encode
  // ----------------------------------------
  // the buffer stalls while fault cycles go out, so the client sees
  // back-pressure rather than silently lost code-bits
  assign fifo_take = !gen_fault;

  prx_fifo #(.W(`PRX_FIFO_W), .DEPTH(`PRX_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(tx_code_valid),
    .in_ready(tx_code_ready),
    .in_data(tx_code_bit),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // an empty buffer sends idle ones so the line never has a gap
  always_comb begin
    if (gen_fault) begin
      code_out = gen_bit;
    end else if (fifo_valid) begin
      code_out = fifo_data;
    end else begin
      code_out = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_nrzi <= 1'b0;
      line_tx_transfer <= 1'b0;
    end else begin
      tx_nrzi <= tx_nrzi ^ code_out;
      line_tx_transfer <= 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_tx_nrzi_code: assert property (
    line_tx_transfer |=> (tx_nrzi != $past(tx_nrzi)) == $past(code_out))
    else $error("tx level change does not match code-bit");
  a_rx_decode_bit: assert property (
    ##2 1'h1 |-> rx_code_bit == ($past(rx_level) ^ $past(rx_level, 2)))
    else $error("received code-bit not decoded from nrzi");
  a_rx_zero_off: assert property (
    (!signal_change_report ##1 !signal_change_report) |=> !rx_code_bit)
    else $error("code-bit seen while signal off");
  a_win_new_bit: assert property (
    line_rx_transfer |-> win[0] == rx_code_bit && win[1] == $past(win[0]))
    else $error("window did not shift in new code-bit");
  a_carrier_rise: assert property (
    $rose(carrier_on) |-> split_zeros(win))
    else $error("carrier on without two split zeros");
  a_carrier_drop: assert property (
    carrier_enable && win == `PRX_IDLE_WIN |-> !carrier_on)
    else $error("carrier still on after ten ones");
  a_ssd_error: assert property (
    cstate == PRX_CARR_CHECK && tail == `PRX_TAIL_LAST && carrier_enable
    && next_win != `PRX_SSD && next_win != `PRX_IDLE_WIN |=> rx_error)
    else $error("bad start delimiter not flagged");
  a_link_fail: assert property (
    !signal_change_report || lc_eff == PRX_LC_DISABLE |=> link_status == PRX_LINK_FAIL)
    else $error("link not failed");
  a_link_qual: assert property (
    link_status != PRX_LINK_FAIL |-> timer == QUAL_CYCLES)
    else $error("link left fail before qualification");
  a_link_enable: assert property (
    link_status == PRX_LINK_READY ##1 link_status == PRX_LINK_OK
    |-> $past(lc_eff) == PRX_LC_ENABLE)
    else $error("link ok without enable");
  a_fef_gen_cycle: assert property (
    gen_fault && gen_cnt == `PRX_FEF_ONES |-> !code_out ##1 (!gen_fault || code_out))
    else $error("fault cycle pattern wrong");
  a_tx_pass: assert property (
    !gen_fault && fifo_valid |-> code_out == fifo_data)
    else $error("transmit code-bit not passed");
  a_fef_report: assert property (
    $rose(far_end_fault) |-> !$past(cbit) && $past(ones) >= `PRX_FEF_ONES)
    else $error("far-end fault raised without full cycle");

  c_carrier: cover property ($rose(carrier_on));
  c_ssd_bad: cover property ($rose(rx_error));
  c_link_ok: cover property ($rose(link_status == PRX_LINK_OK));
  c_fef: cover property ($rose(far_end_fault));

endmodule

`default_nettype wire

// ===== verification/prx_xcvr_model.sv
`default_nettype none

module prx_xcvr_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bench control
  input wire logic code_bit,
  input wire logic sig_on,
  // toward the block
  output logic rx_nrzi,
  output logic signal_change_report
);
  // ------
  // line side
  // ------
  // with no signal the level is junk that flips every cycle, so a
  // block that forgets to mask it sees a changing bit, not a quiet one
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_nrzi <= 1'h0;
    end else if (sig_on) begin
      rx_nrzi <= rx_nrzi ^ code_bit;
    end else begin
      rx_nrzi <= ~rx_nrzi;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      signal_change_report <= 1'h0;
    end else begin
      signal_change_report <= sig_on;
    end
  end
endmodule

`default_nettype wire

// ===== verification/pma_rx_monitors_fault_logic_tb_top.sv
`include "prx_map.svh"

`default_nettype none

module pma_rx_monitors_fault_logic_tb_top
  import prx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, rst, carrier_enable, fef_enable, an_present, code, sig;
  logic rx_nrzi, signal_change_report, tx_nrzi, line_tx_transfer, tx_code_valid;
  logic tx_code_ready, tx_code_bit, line_rx_transfer, rx_code_bit, carrier_on;
  logic rx_error, far_end_fault, h1, h2, last_tx, run, rx_chk, tx_cap, acc;
  prx_link_ctrl_type link_control;
  prx_link_type link_status;
  logic tx_q[$];
  logic [16:0] data;
  int err_count, num_checks, seed, i, k, z, zc;

  prx_top #(.QUAL_CYCLES(16'h0014)) u_dut (
    .mclk, .rst, .carrier_enable, .fef_enable, .an_present, .link_control, .rx_nrzi,
    .signal_change_report, .tx_nrzi, .line_tx_transfer, .tx_code_valid, .tx_code_ready,
    .tx_code_bit, .line_rx_transfer, .rx_code_bit, .carrier_on, .rx_error, .link_status,
    .far_end_fault);

  prx_xcvr_model u_xcvr (.mclk, .rst, .code_bit(code), .sig_on(sig), .rx_nrzi,
    .signal_change_report);

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // ------
  // compare and drive
  // ------
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_link(input prx_link_type got, input prx_link_type exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // nrzi change between two line levels gives the code-bit sent
  function automatic logic nrzi_code(input logic now, input logic was);
    return now ^ was;
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic send(input logic b);
    @(posedge mclk);
    code <= b;
  endtask

  task automatic ones(input int n);
    repeat (n) send(1'h1);
  endtask

  task automatic send_word(input logic [9:0] w);
    for (int j = 9; j >= 0; j--) send(w[j]);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------
  // stream monitor
  // ------
  // code-bits reach rx_code_bit two edges after the bench sets them
  always @(posedge mclk) run <= !rst;

  always @(negedge mclk) begin
    if (run) begin
      chk_bit(line_rx_transfer, 1'h1);
      chk_bit(line_tx_transfer, 1'h1);
      if (rx_chk) chk_bit(rx_code_bit, h2);
      if (tx_cap) tx_q.push_back(nrzi_code(tx_nrzi, last_tx));
    end
    h2 = h1;
    h1 = code;
    last_tx = tx_nrzi;
  end

  initial begin
    #50000;
    err_count++;
    end_of_test();
  end

  // ------
  // main sequence
  // ------
  initial begin
    seed = 32'hD29A;
    rst = 1'h1;
    carrier_enable = 1'h1;
    fef_enable = 1'h1;
    an_present = 1'h0;
    link_control = PRX_LC_ENABLE;
    code = 1'h1;
    sig = 1'h1;
    tx_code_valid = 1'h0;
    tx_code_bit = 1'h0;
    rx_chk = 1'h0;
    tx_cap = 1'h0;
    repeat (6) @(posedge mclk);
    chk_bit(tx_code_ready, 1'h1);
    chk_link(link_status, PRX_LINK_FAIL);
    rst <= 1'h0;
    ones(5);
    rx_chk = 1'h1;
    repeat (200) send(1'($random(seed)));
    ones(12);
    rx_chk = 1'h0;
    @(negedge mclk);
    chk_link(link_status, PRX_LINK_OK);
    // good delimiter, then nine ones must not end the carrier
    send_word(`PRX_SSD);
    send_word(10'h2AA);
    ones(9);
    send(1'h0);
    wt(3);
    chk_bit(carrier_on, 1'h1);
    chk_bit(rx_error, 1'h0);
    ones(12);
    wt(3);
    chk_bit(carrier_on, 1'h0);
    send_word(10'h2BF);
    send_word(10'h155);
    wt(3);
    chk_bit(carrier_on, 1'h1);
    chk_bit(rx_error, 1'h1);
    ones(12);
    wt(3);
    chk_bit(carrier_on, 1'h0);
    chk_bit(rx_error, 1'h0);
    @(posedge mclk);
    carrier_enable <= 1'h0;
    send_word(`PRX_SSD);
    send_word(10'h155);
    wt(3);
    chk_bit(carrier_on, 1'h0);
    ones(12);
    @(posedge mclk);
    carrier_enable <= 1'h1;
    // no signal: fault cycles go out while the fifo is stalled
    tx_cap = 1'h1;
    @(posedge mclk);
    sig <= 1'h0;
    wt(4);
    chk_link(link_status, PRX_LINK_FAIL);
    repeat (8) begin
      chk_bit(rx_code_bit, 1'h0);
      @(negedge mclk);
    end
    for (i = 0; i < 17; i++) data[i] = 1'($random(seed));
    data[0] = 1'h0;
    data[15] = 1'h0;
    i = 0;
    @(posedge mclk);
    tx_code_valid <= 1'h1;
    tx_code_bit <= data[0];
    for (k = 0; k < 40; k++) begin
      @(negedge mclk);
      acc = tx_code_ready;
      @(posedge mclk);
      if (acc) i++;
      tx_code_bit <= data[i];
    end
    tx_code_valid <= 1'h0;
    chk_bit(i == 16, 1'h1);
    wt(300);
    z = -1;
    zc = 0;
    foreach (tx_q[j]) if (tx_q[j] === 1'h0) begin
      if (z >= 0) chk_bit(j - z == 85, 1'h1);
      z = j;
      zc++;
    end
    chk_bit(zc >= 3, 1'h1);
    tx_q.delete();
    @(posedge mclk);
    sig <= 1'h1;
    wt(60);
    z = -1;
    foreach (tx_q[j]) if (tx_q[j] === 1'h0) z = j;
    chk_bit(z >= 15, 1'h1);
    for (k = 0; k < 16; k++) chk_bit(tx_q[z - 15 + k], data[k]);
    tx_cap = 1'h0;
    // without negotiation every control code counts as enable
    for (k = 0; k < 3; k++) begin
      @(posedge mclk);
      link_control <= prx_link_ctrl_type'(k);
      sig <= 1'h0;
      wt(3);
      chk_link(link_status, PRX_LINK_FAIL);
      @(posedge mclk);
      sig <= 1'h1;
      wt(10);
      chk_link(link_status, PRX_LINK_FAIL);
      wt(20);
      chk_link(link_status, PRX_LINK_OK);
    end
    @(posedge mclk);
    an_present <= 1'h1;
    link_control <= PRX_LC_SCAN;
    sig <= 1'h0;
    wt(3);
    @(posedge mclk);
    sig <= 1'h1;
    wt(12);
    @(posedge mclk);
    sig <= 1'h0;
    wt(1);
    @(posedge mclk);
    sig <= 1'h1;
    wt(15);
    chk_link(link_status, PRX_LINK_FAIL);
    wt(15);
    chk_link(link_status, PRX_LINK_READY);
    @(posedge mclk);
    link_control <= PRX_LC_ENABLE;
    wt(2);
    chk_link(link_status, PRX_LINK_OK);
    @(posedge mclk);
    link_control <= PRX_LC_DISABLE;
    wt(2);
    chk_link(link_status, PRX_LINK_FAIL);
    // far-end fault: long first run, then exact cycles
    ones(100);
    send(1'h0);
    ones(84);
    send(1'h0);
    ones(4);
    @(negedge mclk);
    chk_bit(far_end_fault, 1'h0);
    ones(80);
    send(1'h0);
    ones(4);
    @(negedge mclk);
    chk_bit(far_end_fault, 1'h1);
    ones(10);
    send(1'h0);
    ones(4);
    @(negedge mclk);
    chk_bit(far_end_fault, 1'h0);
    @(posedge mclk);
    fef_enable <= 1'h0;
    repeat (3) begin
      ones(84);
      send(1'h0);
    end
    ones(4);
    @(negedge mclk);
    chk_bit(far_end_fault, 1'h0);
    end_of_test();
  end
endmodule

`default_nettype wire
